//--- src/csirq_pkg.sv
// Package with shared constants and carrier types of the counter shell.
package csirq_pkg;

    localparam int NUM_CNT   = 8;
    localparam int NUM_IRQ   = 8;
    localparam int NUM_EVT   = 4;
    localparam int NUM_SRC   = 4;
    localparam int PRL_BITS  = 12;
    localparam int SEL_BITS  = 3;
    localparam int WORD_BITS = 32;
    localparam int HALF_BITS = 16;
    localparam int PAT_BITS  = 8;
    localparam int CAM_BITS  = 16;

    // Counter variant codes.
    localparam logic [1:0] VAR_S16 = 2'h0;
    localparam logic [1:0] VAR_U16 = 2'h1;
    localparam logic [1:0] VAR_S32 = 2'h2;
    localparam logic [1:0] VAR_U32 = 2'h3;

    // Absolute encoder source codes.
    localparam logic [1:0] ENC_NONE = 2'h0;
    localparam logic [1:0] ENC_PRL  = 2'h1;
    localparam logic [1:0] ENC_SSI  = 2'h2;

    localparam logic [WORD_BITS-1:0] CNT_RST = 32'h0000_0000;

    // Per-instance configuration.
    typedef struct packed {
        logic                        present;
        logic [1:0]                  variant;
        logic [1:0]                  enc_src;
        logic [NUM_SRC-1:0]          cnt_en0;
        logic [NUM_SRC-1:0]          cnt_en1;
        logic [NUM_SRC-1:0]          lat_en0;
        logic [NUM_SRC-1:0]          lat_en1;
        logic [NUM_EVT*NUM_CNT*NUM_EVT-1:0] evt_map;
        logic [NUM_EVT-1:0]          evt_out_sel;
        logic [WORD_BITS-1:0]        cmp0;
        logic [WORD_BITS-1:0]        cmp1;
    } csirq_cfg_t;

    // Per-terminal interrupt routing.
    typedef struct packed {
        logic                present;
        logic [SEL_BITS-1:0] src;
    } csirq_irq_cfg_t;

endpackage : csirq_pkg

//--- src/csirq_shell.sv
// Counter shell: eight counter instances and eight interrupt terminals.
module csirq_shell
    import csirq_pkg::*;
#(
    parameter int N_CNT = NUM_CNT,
    parameter int N_IRQ = NUM_IRQ
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire csirq_cfg_t [N_CNT-1:0]     cnt_cfg,
    input  wire csirq_irq_cfg_t [N_IRQ-1:0] irq_cfg,
    input  wire logic [N_CNT-1:0][NUM_SRC-1:0] ext_in,
    input  wire logic [N_CNT-1:0][WORD_BITS-1:0] enc_word,
    input  wire logic [N_CNT-1:0]           enc_load,
    input  wire logic                       irq_ack,
    output logic [N_CNT-1:0]                main_out,
    output logic [N_CNT-1:0][NUM_EVT-1:0]   evt_out,
    output logic [N_CNT-1:0][PAT_BITS-1:0]  pat_out,
    output logic [N_CNT-1:0][CAM_BITS-1:0]  cam_out,
    output logic [N_CNT-1:0][WORD_BITS-1:0] cnt_value,
    output logic [N_CNT-1:0][WORD_BITS-1:0] latch_value,
    output logic                            irq_req,
    output logic [SEL_BITS-1:0]             irq_num
);

    // Pin inputs pass two flip-flops before use.
    logic [N_CNT-1:0][NUM_SRC-1:0]   in_s1_q, in_s2_q;
    logic [N_CNT-1:0][WORD_BITS-1:0] enc_s1_q, enc_s2_q;
    logic [N_CNT-1:0]                ld_s1_q, ld_s2_q, ld_old_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            in_s1_q  <= '0;
            in_s2_q  <= '0;
            enc_s1_q <= '0;
            enc_s2_q <= '0;
            ld_s1_q  <= '0;
            ld_s2_q  <= '0;
            ld_old_q <= '0;
        end else begin
            in_s1_q  <= ext_in;
            in_s2_q  <= in_s1_q;
            enc_s1_q <= enc_word;
            enc_s2_q <= enc_s1_q;
            ld_s1_q  <= enc_load;
            ld_s2_q  <= ld_s1_q;
            ld_old_q <= ld_s2_q;
        end
    end

    // Counter state: two 16-bit halves, or one 32-bit word.
    logic [N_CNT-1:0][WORD_BITS-1:0] cnt_q, cnt_d, lat_q, lat_d;
    logic [N_CNT-1:0][WORD_BITS-1:0] pre_q, pre_d;
    logic [N_CNT-1:0][1:0]           cin_q, cin_d, lin_q, lin_d;
    logic [N_CNT-1:0]                mo_q, mo_d;
    logic [N_CNT-1:0][NUM_EVT-1:0]   eo_q, eo_d;
    logic [N_CNT-1:0][PAT_BITS-1:0]  pat_q, pat_d;
    logic [N_CNT-1:0][CAM_BITS-1:0]  cam_q, cam_d;

    genvar gi;
    generate
        for (gi = 0; gi < N_CNT; gi++) begin : g_cnt
            logic       is16, cin0, cin1, lin0, lin1;
            logic       up0, up1, lt0, lt1, hit0, hit1;
            logic [NUM_EVT-1:0] evt_in;
            logic [HALF_BITS-1:0] h0, h1;

            always_comb begin
                is16 = (cnt_cfg[gi].variant == VAR_S16) ||
                       (cnt_cfg[gi].variant == VAR_U16);
                cin0 = |(in_s2_q[gi] & cnt_cfg[gi].cnt_en0);
                cin1 = |(in_s2_q[gi] & cnt_cfg[gi].cnt_en1);
                lin0 = |(in_s2_q[gi] & cnt_cfg[gi].lat_en0);
                lin1 = is16 && |(in_s2_q[gi] & cnt_cfg[gi].lat_en1);
                for (int e = 0; e < NUM_EVT; e++) begin
                    evt_in[e] = 1'b0;
                    for (int c = 0; c < N_CNT; c++) begin
                        for (int s = 0; s < NUM_EVT; s++) begin
                            evt_in[e] = evt_in[e] |
                                (eo_q[c][s] & cnt_cfg[gi].evt_map[
                                    (e*NUM_CNT+c)*NUM_EVT+s]);
                        end
                    end
                end
                // events 2 and 3 only on 16-bit
                if (!is16) begin
                    evt_in[3:2] = 2'h0;
                end
                up0 = cin0 & ~cin_q[gi][0];
                up1 = cin1 & ~cin_q[gi][1];
                lt0 = (lin0 & ~lin_q[gi][0]) | evt_in[0];
                lt1 = (lin1 & ~lin_q[gi][1]) | evt_in[1];
                cin_d[gi] = {cin1, cin0};
                lin_d[gi] = {lin1, lin0};
                cnt_d[gi] = cnt_q[gi];
                lat_d[gi] = lat_q[gi];
                pre_d[gi] = pre_q[gi];
                h0 = cnt_q[gi][HALF_BITS-1:0];
                h1 = cnt_q[gi][WORD_BITS-1:HALF_BITS];
                if (cnt_cfg[gi].present) begin
                    if (is16) begin
                        h0 = h0 + (up0 ? 16'h0001 : 16'h0000);
                        h1 = h1 + (up1 ? 16'h0001 : 16'h0000);
                        if (evt_in[2]) begin
                            h0 = pre_q[gi][HALF_BITS-1:0];
                        end
                        if (evt_in[3]) begin
                            h1 = pre_q[gi][HALF_BITS-1:0];
                        end
                        cnt_d[gi] = {h1, h0};
                        if (lt0) begin
                            lat_d[gi][HALF_BITS-1:0] = h0;
                        end
                        if (lt1) begin
                            lat_d[gi][WORD_BITS-1:HALF_BITS] = h1;
                        end
                    end else begin
                        cnt_d[gi] = cnt_q[gi] + (up0 ? 32'h1 : 32'h0)
                                    - (up1 ? 32'h1 : 32'h0);
                        if (evt_in[1]) begin
                            cnt_d[gi] = pre_q[gi];
                        end
                        if (lt0) begin
                            lat_d[gi] = cnt_q[gi];
                        end
                    end
                    if (ld_s2_q[gi] && !ld_old_q[gi]) begin
                        if (cnt_cfg[gi].enc_src == ENC_PRL) begin
                            pre_d[gi] = {20'h0, enc_s2_q[gi][PRL_BITS-1:0]};
                        end
                        if (cnt_cfg[gi].enc_src == ENC_SSI) begin
                            cnt_d[gi] = enc_s2_q[gi];
                        end
                    end
                end
                hit0 = is16 ? (cnt_q[gi][HALF_BITS-1:0] ==
                               cnt_cfg[gi].cmp0[HALF_BITS-1:0])
                            : (cnt_q[gi] == cnt_cfg[gi].cmp0);
                hit1 = is16 && (cnt_q[gi][WORD_BITS-1:HALF_BITS] ==
                               cnt_cfg[gi].cmp1[HALF_BITS-1:0]);
                mo_d[gi] = cnt_cfg[gi].present && (hit0 | hit1);
                eo_d[gi] = cnt_cfg[gi].present ?
                    ({hit1, hit0, hit1, hit0} & cnt_cfg[gi].evt_out_sel)
                    : 4'h0;
                if (!is16) begin
                    eo_d[gi][3:2] = 2'h0;
                end
                pat_d[gi] = (cnt_cfg[gi].present &&
                             cnt_cfg[gi].variant == VAR_U16) ?
                            cnt_q[gi][PAT_BITS-1:0] : 8'h00;
                cam_d[gi] = (cnt_cfg[gi].present && !is16) ?
                            cnt_q[gi][CAM_BITS-1:0] : 16'h0000;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= {N_CNT{CNT_RST}};
            lat_q <= {N_CNT{CNT_RST}};
            pre_q <= {N_CNT{CNT_RST}};
            cin_q <= '0;
            lin_q <= '0;
            mo_q  <= '0;
            eo_q  <= '0;
            pat_q <= '0;
            cam_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            lat_q <= lat_d;
            pre_q <= pre_d;
            cin_q <= cin_d;
            lin_q <= lin_d;
            mo_q  <= mo_d;
            eo_q  <= eo_d;
            pat_q <= pat_d;
            cam_q <= cam_d;
        end
    end

    assign main_out    = mo_q;
    assign evt_out     = eo_q;
    assign pat_out     = pat_q;
    assign cam_out     = cam_q;
    assign cnt_value   = cnt_q;
    assign latch_value = lat_q;

    // Interrupt terminals.
    logic [N_IRQ-1:0] term_q, term_d, pend_q, pend_d;
    logic             req_q, req_d;
    logic [SEL_BITS-1:0] num_q, num_d;

    always_comb begin
        for (int t = 0; t < N_IRQ; t++) begin
            // one counter main output per terminal
            term_d[t] = irq_cfg[t].present && mo_q[irq_cfg[t].src];
        end
        pend_d = pend_q;
        req_d  = req_q;
        num_d  = num_q;
        pend_d = pend_d | (term_d & ~term_q);
        if (req_q && irq_ack) begin
            req_d = 1'b0;
        end
        // The request stays low for one cycle after the acknowledge cycle.
        if (!req_q) begin
            for (int t = N_IRQ - 1; t >= 0; t--) begin
                if (pend_q[t]) begin
                    num_d = SEL_BITS'(t);
                end
            end
            if (|pend_q) begin
                req_d = 1'b1;
                pend_d[num_d] = term_d[num_d] & ~term_q[num_d];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            term_q <= '0;
            pend_q <= '0;
            req_q  <= 1'b0;
            num_q  <= '0;
        end else begin
            term_q <= term_d;
            pend_q <= pend_d;
            req_q  <= req_d;
            num_q  <= num_d;
        end
    end

    assign irq_req = req_q;
    assign irq_num = num_q;

endmodule // csirq_shell

//--- verif/csirq_shell_assertions.sv
// Checker of the counter shell interrupt and variant outputs.
module csirq_shell_chk
    import csirq_pkg::*;
#(
    parameter int N_CNT = NUM_CNT,
    parameter int N_IRQ = NUM_IRQ
) (
    input wire logic                           clk_sys,
    input wire logic                           reset,
    input wire csirq_cfg_t [N_CNT-1:0]         cnt_cfg,
    input wire csirq_irq_cfg_t [N_IRQ-1:0]     irq_cfg,
    input wire logic                           irq_ack,
    input wire logic [N_CNT-1:0]               main_out,
    input wire logic [N_CNT-1:0][NUM_EVT-1:0]  evt_out,
    input wire logic [N_CNT-1:0][PAT_BITS-1:0] pat_out,
    input wire logic [N_CNT-1:0][CAM_BITS-1:0] cam_out,
    input wire logic                           irq_req,
    input wire logic [SEL_BITS-1:0]            irq_num
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_req_held: assert property (
        irq_req && !irq_ack |=> irq_req && $stable(irq_num))
        else $error("request changed before ack");
    chk_ack_drop: assert property (
        irq_req && irq_ack |=> !irq_req)
        else $error("request kept after ack");
    chk_rise_term: assert property (
        $rose(irq_req) |-> irq_cfg[irq_num].present)
        else $error("request from absent terminal");
    chk_term_req: assert property (
        irq_cfg[2].present && !irq_req
        && $rose(main_out[irq_cfg[2].src]) |-> ##2 irq_req)
        else $error("terminal edge gave no request");
    chk_reset_clear: assert property (
        $fell(reset) |-> !irq_req && main_out == '0)
        else $error("outputs not clear after reset");

    for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
        chk_pat_var: assert property (
            cnt_cfg[i].variant != VAR_U16 |-> pat_out[i] == '0)
            else $error("pattern output on wrong variant");
        chk_cam_var: assert property (
            !cnt_cfg[i].variant[1] |-> cam_out[i] == '0)
            else $error("cam output on 16-bit variant");
        chk_evt_var: assert property (
            cnt_cfg[i].variant[1] |-> evt_out[i][3:2] == 2'h0)
            else $error("upper events on 32-bit variant");
    end

    cover property (irq_req && irq_ack);
    cover property ($rose(main_out[3]));
    cover property ($rose(irq_req) && irq_num == 3'h6);
endmodule // csirq_shell_chk

bind csirq_shell csirq_shell_chk #(.N_CNT(N_CNT), .N_IRQ(N_IRQ))
    i_csirq_shell_chk (.clk_sys, .reset, .cnt_cfg, .irq_cfg, .irq_ack,
    .main_out, .evt_out, .pat_out, .cam_out, .irq_req, .irq_num);

//--- verif/csirq_host.sv
// Host model that acknowledges interrupt requests and logs their order.
module csirq_host
    import csirq_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                irq_req,
    input  wire logic [SEL_BITS-1:0] irq_num,
    input  wire logic [3:0]          ack_wait,
    output logic                     irq_ack,
    output logic [23:0]              seen_log,
    output logic [7:0]               seen_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;

    initial irq_ack = 1'b0;
    always @(posedge clk_sys) begin
        irq_ack <= 1'b0;
        if (reset) begin
            wait_q   <= 4'h0;
            seen_log <= 24'h0;
            seen_cnt <= 8'h0;
        end else if (irq_req && !irq_ack) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == ack_wait) begin
                irq_ack  <= 1'b1;
                wait_q   <= 4'h0;
                seen_log <= {seen_log[20:0], irq_num};
                seen_cnt <= seen_cnt + 8'h1;
            end
        end
    end
endmodule // csirq_host

//--- verif/testbench.sv
// Self-checking testbench of the counter shell with a host model.
module testbench;
    import csirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                              clk_sys = 1'b0;
    logic                              reset = 1'b1;
    csirq_cfg_t [NUM_CNT-1:0]          cnt_cfg;
    csirq_irq_cfg_t [NUM_IRQ-1:0]      irq_cfg;
    logic [NUM_CNT-1:0][NUM_SRC-1:0]   ext_in = '0;
    logic [NUM_CNT-1:0][WORD_BITS-1:0] enc_word = '0;
    logic [NUM_CNT-1:0]                enc_load = '0;
    logic                              irq_ack, irq_req;
    logic [SEL_BITS-1:0]               irq_num;
    logic [NUM_CNT-1:0]                main_out;
    logic [NUM_CNT-1:0][NUM_EVT-1:0]   evt_out;
    logic [NUM_CNT-1:0][PAT_BITS-1:0]  pat_out;
    logic [NUM_CNT-1:0][CAM_BITS-1:0]  cam_out;
    logic [NUM_CNT-1:0][WORD_BITS-1:0] cnt_value, latch_value;
    logic [3:0]                        ack_wait = 4'h5;
    logic [23:0]                       seen_log;
    logic [7:0]                        seen_cnt;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    csirq_shell i_csirq_shell (.clk_sys, .reset, .cnt_cfg, .irq_cfg,
        .ext_in, .enc_word, .enc_load, .irq_ack, .main_out, .evt_out,
        .pat_out, .cam_out, .cnt_value, .latch_value, .irq_req, .irq_num);
    csirq_host i_csirq_host (.clk_sys, .reset, .irq_req, .irq_num,
        .ack_wait, .irq_ack, .seen_log, .seen_cnt);

    always #12.5 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input int c, input logic [3:0] pins);
        ext_in[c] <= pins;
        @(posedge clk_sys);
        ext_in[c] <= 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic wait_seen(input logic [7:0] n);
        for (int k = 0; k < 40 && seen_cnt !== n; k++) @(posedge clk_sys);
        check(seen_cnt, n);
    endtask

    task automatic test_count();
        pulse(0, 4'h3);
        pulse(0, 4'h4);
        pulse(0, 4'h2);
        check(cnt_value[0], 32'h2);
        check(cam_out[0], 32'h2);
        check(pat_out[0], 32'h0);
        $display("test_count done");
    endtask

    task automatic test_irq();
        pulse(0, 4'h1);
        wait_seen(8'h1);
        check(seen_log[2:0], 32'h2);
        $display("test_irq done");
    endtask

    task automatic test_order();
        ack_wait <= 4'h0;
        pulse(3, 4'h1);
        wait_seen(8'h3);
        check(seen_log[5:0], {26'h0, 3'h1, 3'h6});
        $display("test_order done");
    endtask

    task automatic test_u16();
        pulse(1, 4'h8);
        pulse(1, 4'h8);
        pulse(1, 4'h1);
        check(cnt_value[1], 32'h0001_0002);
        check(pat_out[1], 32'h2);
        check(cam_out[1], 32'h0);
        $display("test_u16 done");
    endtask

    task automatic test_ssi();
        enc_word[2] <= 32'hfedc_ba98;
        enc_load[2] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        enc_load[2] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(cnt_value[2], 32'hfedc_ba98);
        $display("test_ssi done");
    endtask

    task automatic test_evt();
        enc_word[5] <= 32'h1234_5abc;
        enc_load[5] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        enc_load[5] <= 1'b0;
        pulse(4, 4'h1);
        check(cnt_value[5], 32'habc);
        check(evt_out[4], 32'h1);
        check(main_out[4], 32'h1);
        pulse(4, 4'h2);
        check(latch_value[4], 32'h1);
        pulse(4, 4'h1);
        pulse(4, 4'h4);
        check(latch_value[4], 32'h2);
        check(main_out[4], 32'h0);
        pulse(4, 4'h8);
        pulse(4, 4'h8);
        check(cnt_value[4], 32'h0002_0002);
        check(evt_out[4], 32'h0);
        check(main_out[4], 32'h1);
        $display("test_evt done");
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        cnt_cfg = '0;
        irq_cfg = '0;
        for (int c = 0; c < NUM_CNT; c++) begin
            cnt_cfg[c].present = 1'b1;
            cnt_cfg[c].variant = VAR_U32;
            cnt_cfg[c].cmp0 = '1;
            cnt_cfg[c].cmp1 = '1;
        end
        cnt_cfg[0].cnt_en0 = 4'h3;
        cnt_cfg[0].cmp0 = 32'h3;
        cnt_cfg[1].variant = VAR_U16;
        cnt_cfg[1].cnt_en0 = 4'h8;
        cnt_cfg[1].cnt_en1 = 4'h1;
        cnt_cfg[2].variant = VAR_S32;
        cnt_cfg[2].enc_src = ENC_SSI;
        cnt_cfg[3].cnt_en0 = 4'h1;
        cnt_cfg[3].cmp0 = 32'h1;
        cnt_cfg[4].variant = VAR_S16;
        cnt_cfg[4].cnt_en0 = 4'h1;
        cnt_cfg[4].cnt_en1 = 4'h8;
        cnt_cfg[4].lat_en0 = 4'h6;
        cnt_cfg[4].cmp0 = 32'h1;
        cnt_cfg[4].cmp1 = 32'h2;
        cnt_cfg[4].evt_out_sel = 4'h1;
        cnt_cfg[5].enc_src = ENC_PRL;
        // Event input 1 of counter 5 follows event output 0 of counter 4.
        cnt_cfg[5].evt_map[48] = 1'b1;
        irq_cfg[2] = '{1'b1, 3'h0};
        irq_cfg[1] = '{1'b1, 3'h3};
        irq_cfg[6] = '{1'b1, 3'h3};
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        test_count();
        test_irq();
        test_order();
        test_u16();
        test_ssi();
        test_evt();
        results();
    end
endmodule // testbench
